// *** inc/hbmd_pkg.sv ***
/*
 Package for the H-bridge motor drive block: bridge functions, input
 encodings and the reset values of the pin samples.
 Assumes a single clock domain and a synchronous active-high reset.
*/
package hbmd_pkg;

    typedef enum logic [1:0] {
        HBMD_COAST,
        HBMD_REVERSE,
        HBMD_FORWARD,
        HBMD_BRAKE
    } hbmd_func_t;

    // Encodings of the two driver inputs, first input in the high bit
    localparam logic [1:0] HBMD_IN_COAST = 2'h0;
    localparam logic [1:0] HBMD_IN_REVERSE = 2'h1;
    localparam logic [1:0] HBMD_IN_FORWARD = 2'h2;
    localparam logic [1:0] HBMD_IN_BRAKE = 2'h3;

    // Reset values
    localparam logic HBMD_RST_WAKE = 1'h0;
    localparam logic [1:0] HBMD_RST_INPUTS = 2'h0;
    localparam logic HBMD_RST_READY = 1'h0;

    // Width of the counter of drive-phase cycles accumulated while awake
    localparam int HBMD_CNT_W = 16;
    localparam logic [15:0] HBMD_CNT_ZERO = 16'h0000;
    localparam logic [15:0] HBMD_CNT_MAX = 16'hFFFF;

endpackage

// *** src/hbmd_decode.sv ***
/*
 Bridge function decoder for the H-bridge motor drive block.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/10ps
module hbmd_decode
    import hbmd_pkg::*;
(
    // Driver pins
    input wire logic driver_wake_line,
    input wire logic direction_input_a,
    input wire logic pwm_input_b,
    // Decoded function
    output hbmd_func_t func
);

    always_comb begin
        if (!driver_wake_line) begin
            func = HBMD_COAST; // R1
        end else begin
            unique case ({direction_input_a, pwm_input_b})
                HBMD_IN_COAST: func = HBMD_COAST; // R1
                HBMD_IN_REVERSE: func = HBMD_REVERSE;
                HBMD_IN_FORWARD: func = HBMD_FORWARD;
                HBMD_IN_BRAKE: func = HBMD_BRAKE;
            endcase
        end
    end

endmodule

// *** src/hbmd_bridge.sv ***
/*
 Device-side logic of the H-bridge motor drive: decodes wake and the two
 driver inputs into the bridge function, drives the four half-bridge
 gate controls, tracks PWM drive/recirculate phases, and answers the
 readiness handshake of the coprocessor serial link.
 Assumes all inputs are synchronous to core_clk.
*/
// Overview of operation
// R1: Wake low coasts; awake inputs decode 00 coast, 01 reverse, 10 forward, 11 brake.
// R2: Controller drives first input from plain output, second from PWM output.
// R3: Controller holds active-low sleep line high whenever the motor runs.
// R4: Forward: controller sets wake and first input high, PWM second input.
// R5: First input high with pulsed second input alternates forward and brake.
// R6: Reverse: controller sets wake high, first input low, PWM second input.
// R7: First input low with pulsed second input alternates reverse and coast.
// R8: Host provides coprocessor reset; each side has its own ready line.
// R9: Controller stops by driving inputs low then wake low; duty is configurable.
`timescale 1ns/10ps
module hbmd_bridge
    import hbmd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Driver control pins from the controller
    input wire logic driver_wake_line,
    input wire logic direction_input_a,
    input wire logic pwm_input_b,
    // Serial link sideband
    input wire logic host_reset,
    input wire logic host_side_ready,
    input wire logic local_ready,
    output logic coprocessor_side_ready,
    // Half-bridge gate controls
    output logic out1_high_on,
    output logic out1_low_on,
    output logic out2_high_on,
    output logic out2_low_on,
    // Status
    output hbmd_func_t bridge_func,
    output logic driving,
    output logic fwd_brake_mode,
    output logic rev_coast_mode,
    output logic [15:0] drive_cycles
);

    typedef struct packed {
        hbmd_func_t func;
        logic g1h;
        logic g1l;
        logic g2h;
        logic g2l;
        logic drv;
        logic fwd_pwm;
        logic rev_pwm;
        logic b_prev;
        logic toggled_hi;
        logic toggled_lo;
        logic rdy;
        logic [15:0] cnt;
    } hbmd_state_t;

    hbmd_state_t st_r;
    hbmd_state_t st_nxt;
    hbmd_func_t dec_func;

    hbmd_decode u_decode (
        .driver_wake_line(driver_wake_line),
        .direction_input_a(direction_input_a),
        .pwm_input_b(pwm_input_b),
        .func(dec_func)
    );

    // Saturating increment; the count is a diagnostic, wrap would mislead
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == HBMD_CNT_MAX) ? v : v + 16'h0001;
    endfunction

    always_comb begin
        st_nxt = st_r;
        st_nxt.func = dec_func; // R1
        // Gates: never both switches of one leg on, so no shoot-through
        st_nxt.g1h = 1'b0;
        st_nxt.g1l = 1'b0;
        st_nxt.g2h = 1'b0;
        st_nxt.g2l = 1'b0;
        unique case (dec_func)
            HBMD_COAST: begin
                st_nxt.drv = 1'b0; // R1
            end
            HBMD_FORWARD: begin
                st_nxt.g1h = 1'b1;
                st_nxt.g2l = 1'b1;
                st_nxt.drv = 1'b1;
            end
            HBMD_REVERSE: begin
                st_nxt.g2h = 1'b1;
                st_nxt.g1l = 1'b1;
                st_nxt.drv = 1'b1;
            end
            HBMD_BRAKE: begin
                st_nxt.g1l = 1'b1;
                st_nxt.g2l = 1'b1;
                st_nxt.drv = 1'b0;
            end
        endcase
        // PWM phase tracking: both edges of the second input seen while awake
        st_nxt.b_prev = pwm_input_b;
        if (!driver_wake_line || (direction_input_a != st_r.func[1] && st_r.drv)) begin
            st_nxt.toggled_hi = 1'b0;
            st_nxt.toggled_lo = 1'b0;
        end else if (pwm_input_b && !st_r.b_prev) begin
            st_nxt.toggled_hi = 1'b1;
        end else if (!pwm_input_b && st_r.b_prev) begin
            st_nxt.toggled_lo = 1'b1;
        end
        st_nxt.fwd_pwm = driver_wake_line && direction_input_a
            && st_nxt.toggled_hi && st_nxt.toggled_lo; // R5
        st_nxt.rev_pwm = driver_wake_line && !direction_input_a
            && st_nxt.toggled_hi && st_nxt.toggled_lo; // R7
        // Drive-phase count, cleared when the bridge goes to sleep
        if (!driver_wake_line) begin
            st_nxt.cnt = HBMD_CNT_ZERO;
        end else if (st_nxt.drv) begin
            st_nxt.cnt = sat_inc(st_r.cnt);
        end
        // Ready line drops while the host holds the coprocessor in reset
        st_nxt.rdy = !host_reset && local_ready; // R8
        if (host_side_ready && !host_reset) begin
            st_nxt.rdy = 1'b1; // R8
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r <= '0;
            st_r.func <= HBMD_COAST;
            st_r.rdy <= HBMD_RST_READY;
            st_r.b_prev <= HBMD_RST_INPUTS[0];
        end else begin
            st_r <= st_nxt;
        end
    end

    assign coprocessor_side_ready = st_r.rdy;
    assign out1_high_on = st_r.g1h;
    assign out1_low_on = st_r.g1l;
    assign out2_high_on = st_r.g2h;
    assign out2_low_on = st_r.g2l;
    assign bridge_func = st_r.func;
    assign driving = st_r.drv;
    assign fwd_brake_mode = st_r.fwd_pwm;
    assign rev_coast_mode = st_r.rev_pwm;
    assign drive_cycles = st_r.cnt;

endmodule

// *** tb/hbmd_bridge_checker.sv ***
/* Port assertions for hbmd_bridge.
   Assumes one clock and a sync reset. */
`timescale 1ns/10ps
module hbmd_bridge_checker
    import hbmd_pkg::*;
(
    // Clock, reset and pins
    input wire logic core_clk,
    input wire logic srst,
    input wire logic driver_wake_line,
    input wire logic direction_input_a,
    input wire logic pwm_input_b,
    input wire logic host_reset,
    // Outputs
    input wire logic coprocessor_side_ready,
    input wire hbmd_func_t bridge_func
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    wire logic [2:0] p = {driver_wake_line, direction_input_a, pwm_input_b};
    chk_awake_decode: assert property (p[2] |=> bridge_func == $past(p[1:0])) else $error("decode");
    chk_sleep_coast: assert property (!p[2] |=> bridge_func == HBMD_COAST) else $error("asleep");
    chk_fwd_brake: assert property (p[2:1] == 2'h3 |=> bridge_func inside {HBMD_FORWARD, HBMD_BRAKE})
        else $error("fwd");
    chk_rev_coast: assert property (p[2:1] == 2'h2 |=> bridge_func inside {HBMD_REVERSE, HBMD_COAST})
        else $error("rev");
    chk_ready_held: assert property (host_reset |=> !coprocessor_side_ready) else $error("ready");
endmodule
bind hbmd_bridge hbmd_bridge_checker hbmd_bridge_checker_i (.core_clk(core_clk), .srst(srst),
    .driver_wake_line(driver_wake_line), .direction_input_a(direction_input_a),
    .pwm_input_b(pwm_input_b), .host_reset(host_reset),
    .coprocessor_side_ready(coprocessor_side_ready), .bridge_func(bridge_func));

// *** tb/hbmd_ctrl_model.sv ***
/* Controller model driving wake and the two driver inputs.
   Assumes run and fwd change off the clock edge. */
`timescale 1ns/10ps
module hbmd_ctrl_model #(parameter int DUTY = 2) (
    // Clock and commands
    input wire logic core_clk,
    input wire logic srst,
    input wire logic run,
    input wire logic fwd,
    // Driver pins
    output logic driver_wake_line,
    output logic direction_input_a,
    output logic pwm_input_b
);
    logic [1:0] phase_r;
    always_ff @(posedge core_clk) begin
        phase_r <= srst ? 2'h0 : phase_r + 2'h1;
        // Old inputs keep wake up one cycle longer, so inputs drop first
        driver_wake_line <= !srst && (run || direction_input_a || pwm_input_b);
        direction_input_a <= !srst && run && fwd;
        pwm_input_b <= !srst && run && (phase_r < DUTY);
    end
endmodule

// *** tb/hbmd_bridge_test.sv ***
/* Bench for hbmd_bridge with the controller model.
   Assumes one cycle from pins to outputs. */
`timescale 1ns/10ps
module hbmd_bridge_test
    import hbmd_pkg::*;
;
    logic core_clk = 0, srst = 1, sel = 0, run = 0, fwd = 0;
    logic [2:0] pins = 3'h0, sb = 3'h0;
    logic mw, ma, mb, rdy, fb, rc, drv;
    logic [3:0] gates;
    logic [15:0] dcy;
    logic [3:0] gate_exp [4] = '{4'h0, 4'h6, 4'h9, 4'h5};
    hbmd_func_t func;
    int bad_count = 0, n_tests = 0;
    always #4 core_clk = !core_clk;
    hbmd_ctrl_model hbmd_ctrl_model_i (.core_clk(core_clk), .srst(srst), .run(run),
        .fwd(fwd), .driver_wake_line(mw), .direction_input_a(ma), .pwm_input_b(mb));
    hbmd_bridge hbmd_bridge_i (.core_clk(core_clk), .srst(srst),
        .driver_wake_line(sel ? mw : pins[2]), .direction_input_a(sel ? ma : pins[1]),
        .pwm_input_b(sel ? mb : pins[0]), .host_reset(sb[2]), .host_side_ready(sb[1]),
        .local_ready(sb[0]), .coprocessor_side_ready(rdy), .out1_high_on(gates[3]),
        .out1_low_on(gates[2]), .out2_high_on(gates[1]), .out2_low_on(gates[0]),
        .bridge_func(func), .driving(drv), .fwd_brake_mode(fb), .rev_coast_mode(rc),
        .drive_cycles(dcy));
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic t_pins;
        for (int i = 0; i < 8; i++) begin
            pins = i[2:0];
            sb = i[2:0];
            step(1);
            check("func", func, i[2] ? i[1:0] : 2'h0);
            check("gates", gates, gate_exp[i[2] ? i[1:0] : 2'h0]);
            check("driving", drv, i[2] && (i[1] ^ i[0]));
            check("ready", rdy, !i[2] && (i[1] || i[0]));
            // Drive cycles only accrue at the reverse and forward steps
            check("cycles", dcy[3:0], (i < 5) ? 4'h0 : ((i == 5) ? 4'h1 : 4'h2));
            check("cycles_hi", dcy[15:12], 4'h0);
        end
        pins = 3'h0;
    endtask
    task automatic t_pwm(input logic dir, input hbmd_func_t on_f, input hbmd_func_t off_f);
        int n_on = 0, n_off = 0;
        sel = 1;
        fwd = dir;
        run = 1;
        step(4);
        // Sixteen cycles span whole PWM periods whatever the phase
        for (int k = 0; k < 16; k++) begin
            step(1);
            n_on += (func === on_f);
            n_off += (func === off_f);
        end
        check("on", n_on[3:0], 4'h8);
        check("off", n_off[3:0], 4'h8);
        check("mode", dir ? fb : rc, 1'b1);
        run = 0;
        step(3);
        check("stop", func, HBMD_COAST);
        check("cycles_clear", dcy[3:0], 4'h0);
        sel = 0;
    endtask
    initial begin
        step(10);
        check("reset", func, HBMD_COAST);
        srst = 0;
        step(1);
        t_pins;
        t_pwm(1'b1, HBMD_FORWARD, HBMD_BRAKE);
        t_pwm(1'b0, HBMD_REVERSE, HBMD_COAST);
        complete_run;
    end
    initial begin
        #20000;
        bad_count++;
        complete_run;
    end
endmodule
